// ---- src/mfc_defines.svh ----
`ifndef MFC_DEFINES_SVH
`define MFC_DEFINES_SVH
// register byte offsets
`define MFC_ADR_CTRL_A    8'h00
`define MFC_ADR_CTRL_B    8'h04
`define MFC_ADR_STATUS    8'h08
`define MFC_ADR_TMR_MODE  8'h0C
`define MFC_ADR_TMR_CTRL  8'h10
`define MFC_ADR_TIMER     8'h14
`define MFC_ADR_RELOAD    8'h18
`define MFC_ADR_IRQ_EN    8'h1C
`define MFC_ADR_CAP0      8'h20
`define MFC_ADR_CAP1      8'h24
`define MFC_ADR_CAP2      8'h28
`define MFC_ADR_QEI_CTRL  8'h2C
// field positions
`define MFC_TM_RELOAD_EN  0
`define MFC_TM_CLR_ON_CAP 3
`define MFC_TC_CMP_SEL    0
`define MFC_TC_RUN        1
`define MFC_IE_CAPTURE    0
`define MFC_IE_TIMER      1
`define MFC_QC_ENABLE     0
`define MFC_QC_IDX_DIS    1
`define MFC_QC_MODE_LO    2
`define MFC_ST_TMR_FLAG   3
`define MFC_ST_DIR        4
`define MFC_CB_FILTER_LO  3
`define MFC_CA_RLD_SRC_LO 6
// reset values and limits
`define MFC_RST_ZERO16    16'h0000
`define MFC_CNT_MAX       16'hFFFF
`define MFC_FILTER_LEN    4
`endif

// ---- src/mfc_pkg.sv ----
package mfc_pkg;
	// edge choice for a capture channel
	typedef enum logic [1:0] {
		MFC_EDGE_RISE = 2'h0,
		MFC_EDGE_FALL = 2'h1,
		MFC_EDGE_BOTH = 2'h2,
		MFC_EDGE_ALT  = 2'h3
	} mfc_edge_t;
	// per-channel configuration
	typedef struct packed {
		logic      filterOn;
		logic      enable;
		mfc_edge_t trig;
	} mfc_chan_cfg_t;
	// timer configuration
	typedef struct packed {
		logic cmpSel;
		logic run;
		logic reloadEn;
		logic clrOnCap;
	} mfc_tmr_cfg_t;
endpackage : mfc_pkg

// ---- src/mfc_capture_qei.sv ----
`include "mfc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module mfc_capture_qei
	import mfc_pkg::*;
#(
	parameter int FILTER_LEN = `MFC_FILTER_LEN
)(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output var  logic [31:0] wb_dat_o,
	output var  logic        wb_ack_o,
	// capture and encoder pins
	input  wire logic [2:0]  capturePin,
	// interrupt requests
	output var  logic        captureIrq,
	output var  logic        timerIrq
);
	if (FILTER_LEN < 3)
	begin : gBadLen
		$error("FILTER_LEN must be at least 3");
	end

	logic          ackFf, tmrFlagFf, dirFf, wrEn, encoder_if_enable, idxDis;
	logic          x2Mode, cmpCount, aEdge, bEdge, qEv, qUp, qWrap;
	logic          capClr, rlCap, tmrWrap, tmrFlagSet;
	logic [31:0]   rdFf, wdat, selMask;
	logic [7:0]    ctrlAFf;
	logic [5:0]    ctrlBFf;
	logic [3:0]    tmodFf, qctrlFf;
	logic [1:0]    tctrlFf, irqEnFf;
	logic [15:0]   timerFf, rcapFf, cap0Ff, cap1Ff, cap2Ff, cntFf;
	logic [15:0]   latchFf, maxFf, reloadVal, nxt_timer, nxt_cnt;
	logic [2:0]    capFlagFf, sync1Ff, sync2Ff, lvlFf, prevFf, nxtLvl;
	logic [2:0]    rise, fall, trig, capEvt, flagSet, flagClr;
	mfc_chan_cfg_t cfg [3];
	mfc_tmr_cfg_t  tcfg;

	// bus handshake: ack one cycle after request, write at ack edge
	assign wrEn     = wb_cyc_i && wb_stb_i && wb_we_i && ackFf;
	assign wb_ack_o = ackFf;
	assign wb_dat_o = rdFf;
	assign selMask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wdat     = wb_dat_i & selMask;      // unselected lanes write 0, except in TIMER, which keeps them

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ackFf <= 1'b0;
		else
			ackFf <= wb_cyc_i && wb_stb_i && !ackFf;
	end

	// configuration decode
	assign encoder_if_enable    = qctrlFf[`MFC_QC_ENABLE];
	assign idxDis   = qctrlFf[`MFC_QC_IDX_DIS];
	assign x2Mode   = qctrlFf[`MFC_QC_MODE_LO];
	assign cmpCount = qctrlFf[`MFC_QC_MODE_LO+1];
	assign tcfg     = '{cmpSel:   tctrlFf[`MFC_TC_CMP_SEL],
		run:      tctrlFf[`MFC_TC_RUN],
		reloadEn: tmodFf[`MFC_TM_RELOAD_EN],
		clrOnCap: tmodFf[`MFC_TM_CLR_ON_CAP]};

	// control registers, zero at reset so capture mode is default
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrlAFf <= 8'h00;
			ctrlBFf <= 6'h00;
			tmodFf  <= 4'h0;
			tctrlFf <= 2'h0;
			irqEnFf <= 2'h0;
			qctrlFf <= 4'h0;
			rcapFf  <= `MFC_RST_ZERO16;
			maxFf   <= `MFC_RST_ZERO16;
		end
		else if (wrEn)
		begin
			case (wb_adr_i)
				`MFC_ADR_CTRL_A:   ctrlAFf <= wdat[7:0];
				`MFC_ADR_CTRL_B:   ctrlBFf <= wdat[5:0];
				`MFC_ADR_TMR_MODE: tmodFf  <= wdat[3:0];
				`MFC_ADR_TMR_CTRL: tctrlFf <= wdat[1:0];
				`MFC_ADR_IRQ_EN:   irqEnFf <= wdat[1:0];
				`MFC_ADR_QEI_CTRL: qctrlFf <= wdat[3:0];
				`MFC_ADR_RELOAD:   rcapFf  <= wdat[15:0];
				`MFC_ADR_CAP2:
					if (encoder_if_enable)
						maxFf <= wdat[15:0];
				default: ;
			endcase
		end
	end

	// read mux, captured with the request, shown with ack
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdFf <= 32'h0000_0000;
		else if (wb_cyc_i && wb_stb_i && !ackFf)
		begin
			case (wb_adr_i)
				`MFC_ADR_CTRL_A:   rdFf <= {24'h0, ctrlAFf};
				`MFC_ADR_CTRL_B:   rdFf <= {26'h0, ctrlBFf};
				`MFC_ADR_STATUS:
					rdFf <= {27'h0, dirFf, tmrFlagFf, capFlagFf};
				`MFC_ADR_TMR_MODE: rdFf <= {28'h0, tmodFf};
				`MFC_ADR_TMR_CTRL: rdFf <= {30'h0, tctrlFf};
				`MFC_ADR_TIMER:    rdFf <= {16'h0, timerFf};
				`MFC_ADR_RELOAD:   rdFf <= {16'h0, rcapFf};
				`MFC_ADR_IRQ_EN:   rdFf <= {30'h0, irqEnFf};
				`MFC_ADR_QEI_CTRL: rdFf <= {28'h0, qctrlFf};
				// encoder mode remaps the capture words
				`MFC_ADR_CAP0:
					rdFf <= {16'h0, encoder_if_enable ? latchFf : cap0Ff};
				`MFC_ADR_CAP1:
					rdFf <= {16'h0, encoder_if_enable ? cntFf : cap1Ff};
				`MFC_ADR_CAP2:
					rdFf <= {16'h0, encoder_if_enable ? maxFf : cap2Ff};
				default:           rdFf <= 32'h0000_0000;
			endcase
		end
	end

	// two-stage synchroniser on every pin
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sync1Ff <= 3'h0;
			sync2Ff <= 3'h0;
		end
		else
		begin
			sync1Ff <= capturePin;
			sync2Ff <= sync1Ff;
		end
	end

	// per-channel noise filter and edge select
	for (genvar g = 0; g < 3; g++)
	begin : gChan
		logic [FILTER_LEN-2:0] histFf;
		logic [FILTER_LEN-1:0] win;
		assign cfg[g] = '{filterOn: ctrlBFf[`MFC_CB_FILTER_LO+g],
			enable: ctrlBFf[g],
			trig: mfc_edge_t'(ctrlAFf[2*g +: 2])};
		assign win = {histFf, sync2Ff[g]};
		always_ff @(posedge clk)
		begin
			if (!rst_n)
				histFf <= '0;
			else
				histFf <= win[FILTER_LEN-2:0];
		end
		// with the filter on, level moves only when the whole window agrees; with it off, level follows the synchroniser
		assign nxtLvl[g] = !cfg[g].filterOn ? sync2Ff[g] :
			(&win) ? 1'b1 : (~|win) ? 1'b0 : lvlFf[g];
		assign rise[g] = lvlFf[g] && !prevFf[g];
		assign fall[g] = !lvlFf[g] && prevFf[g];
		assign trig[g] = (cfg[g].trig == MFC_EDGE_RISE) ? rise[g] :
			(cfg[g].trig == MFC_EDGE_FALL) ? fall[g] :
			(rise[g] || fall[g]);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			lvlFf  <= 3'h0;
			prevFf <= 3'h0;
		end
		else
		begin
			lvlFf  <= nxtLvl;
			prevFf <= lvlFf;
		end
	end

	// capture events; pins 0/1 belong to the encoder when enabled
	assign capEvt[0] = trig[0] && cfg[0].enable && !encoder_if_enable;
	assign capEvt[1] = trig[1] && cfg[1].enable && !encoder_if_enable;
	assign capEvt[2] = trig[2] && cfg[2].enable &&
		(!encoder_if_enable || !idxDis);

	// capture registers take the shared timer
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cap0Ff <= `MFC_RST_ZERO16;
			cap1Ff <= `MFC_RST_ZERO16;
			cap2Ff <= `MFC_RST_ZERO16;
		end
		else
		begin
			if (capEvt[0])
				cap0Ff <= timerFf;
			if (capEvt[1])
				cap1Ff <= timerFf;
			if (capEvt[2] && !encoder_if_enable)
				cap2Ff <= timerFf;
		end
	end

	// shared timer: clear-on-capture, pin reload, compare, overflow
	assign capClr    = (|capEvt[1:0] || (capEvt[2] && !encoder_if_enable)) &&
		tcfg.clrOnCap;
	assign rlCap     = (ctrlAFf[`MFC_CA_RLD_SRC_LO +: 2] != 2'h0) &&
		capEvt[ctrlAFf[`MFC_CA_RLD_SRC_LO +: 2] - 2'h1] && !encoder_if_enable;
	assign reloadVal = (tcfg.reloadEn && !tcfg.clrOnCap) ?
		rcapFf : `MFC_RST_ZERO16;
	assign tmrWrap   = tcfg.cmpSel ? (timerFf == rcapFf) :
		(timerFf == `MFC_CNT_MAX);
	assign tmrFlagSet = tcfg.run && tmrWrap && !capClr && !rlCap;

	always_comb
	begin
		nxt_timer = timerFf;
		if (capClr)
			nxt_timer = `MFC_RST_ZERO16;
		else if (rlCap)
			nxt_timer = reloadVal;
		else if (wrEn && wb_adr_i == `MFC_ADR_TIMER)
			nxt_timer = (timerFf & ~selMask[15:0]) | wdat[15:0];
		else if (tcfg.run && tmrWrap)
			nxt_timer = tcfg.cmpSel ? `MFC_RST_ZERO16 : reloadVal;
		else if (tcfg.run)
			nxt_timer = timerFf + 16'h0001;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			timerFf <= `MFC_RST_ZERO16;
		else
			timerFf <= nxt_timer;
	end

	// quadrature decode: edge, direction and count pulse
	assign aEdge = lvlFf[0] ^ prevFf[0];
	assign bEdge = lvlFf[1] ^ prevFf[1];
	assign qEv   = encoder_if_enable && aEdge != bEdge && (!x2Mode || aEdge);
	assign qUp   = aEdge ? (lvlFf[0] ^ lvlFf[1]) :
		!(lvlFf[0] ^ lvlFf[1]);
	assign qWrap = qUp ? (cntFf == (cmpCount ? maxFf : `MFC_CNT_MAX)) :
		(cntFf == `MFC_RST_ZERO16);

	always_comb
	begin
		nxt_cnt = cntFf;
		if (wrEn && encoder_if_enable && wb_adr_i == `MFC_ADR_CAP1)
			nxt_cnt = wdat[15:0];
		else if (qEv && qUp)
			nxt_cnt = qWrap ? `MFC_RST_ZERO16 : cntFf + 16'h0001;
		else if (qEv)
			nxt_cnt = !qWrap ? cntFf - 16'h0001 :
				(cmpCount ? maxFf : `MFC_CNT_MAX);
	end

	// counter, latched copy (frozen while it is being read) and direction
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cntFf   <= `MFC_RST_ZERO16;
			latchFf <= `MFC_RST_ZERO16;
			dirFf   <= 1'b0;
		end
		else
		begin
			cntFf <= nxt_cnt;
			if (!(wb_cyc_i && wb_stb_i && wb_adr_i == `MFC_ADR_CAP0))
				latchFf <= cntFf;
			if (qEv)
				dirFf <= qUp;
		end
	end

	// sticky flags: set wins over a write-one clear
	assign flagSet[0] = capEvt[0] || (qEv && qWrap);
	assign flagSet[1] = capEvt[1] || (qEv && qUp != dirFf);
	assign flagSet[2] = capEvt[2];
	assign flagClr    = (wrEn && wb_adr_i == `MFC_ADR_STATUS) ?
		wdat[2:0] : 3'h0;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			capFlagFf <= 3'h0;
			tmrFlagFf <= 1'b0;
		end
		else
		begin
			capFlagFf <= (capFlagFf & ~flagClr) | flagSet;
			tmrFlagFf <= (tmrFlagFf && !(flagClr != 3'h0 ? 1'b0 :
				wrEn && wb_adr_i == `MFC_ADR_STATUS &&
				wdat[`MFC_ST_TMR_FLAG])) || tmrFlagSet;
		end
	end

	// interrupt requests
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			captureIrq <= 1'b0;
			timerIrq   <= 1'b0;
		end
		else
		begin
			captureIrq <= irqEnFf[`MFC_IE_CAPTURE] && |capFlagFf;
			timerIrq   <= irqEnFf[`MFC_IE_TIMER] && tmrFlagFf;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_filter_four_eq: assert property (
		($past(cfg[0].filterOn) && lvlFf[0] != $past(lvlFf[0])) |->
		($past(sync2Ff[0], 1) == lvlFf[0] && $past(sync2Ff[0], 2) ==
		lvlFf[0] && $past(sync2Ff[0], 3) == lvlFf[0] &&
		$past(sync2Ff[0], 4) == lvlFf[0]))
		else $error("filter passed an unstable level");
	a_capture_copy: assert property (
		capEvt[0] |=> cap0Ff == $past(timerFf))
		else $error("capture missed timer value");
	a_flag_sticky: assert property (
		(capFlagFf[0] && flagClr[0] == 1'b0) |=> capFlagFf[0])
		else $error("capture flag lost without clear");
	a_clear_on_cap: assert property (
		capClr |=> timerFf == 16'h0000)
		else $error("timer not cleared after capture");
	a_cmp_restart: assert property (
		(tcfg.cmpSel && tmrFlagSet) |=> timerFf == 16'h0000 && tmrFlagFf)
		else $error("compare match did not restart");
	a_reload_ovf: assert property (
		(!tcfg.cmpSel && tmrFlagSet && !wrEn) |=>
		timerFf == $past(reloadVal))
		else $error("overflow reload value wrong");
	a_ch2_gate: assert property (
		capEvt[2] |-> cfg[2].enable && (!encoder_if_enable || !idxDis))
		else $error("channel 2 fired while gated");
	a_count_hold: assert property (
		!encoder_if_enable |=> $stable(cntFf))
		else $error("counter moved while encoder off");
	a_wrap_cmp: assert property (
		(qEv && qUp && cmpCount && cntFf == maxFf && !wrEn) |=>
		cntFf == 16'h0000 && capFlagFf[0])
		else $error("limit wrap wrong");
	a_dir_lead: assert property (
		(qEv && aEdge && lvlFf[0] != lvlFf[1]) |=> dirFf)
		else $error("direction not set on lead");
	c_capture: cover property (capEvt[0] ##1 captureIrq);
	c_compare: cover property (tcfg.cmpSel && tmrFlagSet);
	c_qei_wrap: cover property (qEv && qWrap);
	c_dir_flip: cover property (qEv && qUp != dirFf);
endmodule : mfc_capture_qei
`default_nettype wire

// ---- sim/mfc_encoder_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module mfc_encoder_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// step requests and raw levels
	input  wire logic       stepUp,
	input  wire logic       stepDown,
	input  wire logic       rawMode,
	input  wire logic [2:0] rawPins,
	// pins toward the block
	output var  logic [2:0] pins
);
	logic [1:0] phase_ff;

	// quadrature position, one quarter period per step
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			phase_ff <= 2'h0;
		else if (stepUp)
			phase_ff <= phase_ff + 2'h1;
		else if (stepDown)
			phase_ff <= phase_ff - 2'h1;
	end

	// phase a on pin 0 leads phase b on pin 1 when stepping up
	always_comb
	begin
		if (rawMode)
			pins = rawPins;
		else
			pins = {rawPins[2], phase_ff[1], ^phase_ff};
	end
endmodule : mfc_encoder_model
`default_nettype wire

// ---- sim/mfc_capture_qei_tb.sv ----
`include "mfc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module mfc_capture_qei_tb
	import mfc_pkg::*;
;
	typedef struct {
		logic [7:0]  a;
		logic [31:0] e;
	} mfc_row_t;

	logic        clk, rst_n, cyc, we, ack, capIrq, tmrIrq;
	logic        stepUp, stepDown, rawMode;
	logic [7:0]  adr;
	logic [31:0] wdat, rdOut, rd;
	logic [2:0]  rawPins, pins;
	int          err_count, cmp_count, cycles;
	mfc_row_t    rows [6] = '{'{`MFC_ADR_CTRL_A, 32'hFF},
		'{`MFC_ADR_CTRL_B, 32'h3F}, '{`MFC_ADR_TMR_MODE, 32'h0F},
		'{`MFC_ADR_RELOAD, 32'hFFFF}, '{`MFC_ADR_IRQ_EN, 32'h03},
		'{8'h30, 32'h00}};

	mfc_capture_qei #(.FILTER_LEN(4)) i_dut (.clk(clk), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdOut),
		.wb_ack_o(ack), .capturePin(pins), .captureIrq(capIrq),
		.timerIrq(tmrIrq));

	mfc_encoder_model i_enc (.clk(clk), .rst_n(rst_n), .stepUp(stepUp),
		.stepDown(stepDown), .rawMode(rawMode), .rawPins(rawPins),
		.pins(pins));

	// clock source
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			$display("mismatch at %0t: run too long", $time);
			complete_run();
		end
	end

	task automatic complete_run;
		if (err_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	// classic single wishbone cycle, held until ack is sampled
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		rd = rdOut;
		cyc <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdChk

	task automatic pin(input logic [2:0] v, input int hold);
		@(posedge clk);
		rawPins <= v;
		repeat (hold) @(posedge clk);
	endtask : pin

	task automatic steps(input int n, input logic up);
		repeat (n)
		begin
			@(posedge clk);
			stepUp   <= up;
			stepDown <= !up;
			@(posedge clk);
			stepUp   <= 1'b0;
			stepDown <= 1'b0;
			repeat (10) @(posedge clk);
		end
	endtask : steps

	// main sequence
	initial
	begin
		{rst_n, cyc, we, adr, wdat, stepUp, stepDown} = '0;
		{rawPins, err_count, cmp_count, cycles} = '0;
		rawMode = 1'b1;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rdChk(`MFC_ADR_QEI_CTRL, 32'h0);
		rdChk(`MFC_ADR_STATUS, 32'h0);
		chk(capIrq, 32'h0);
		// register rows: all ones in, masked fields back
		foreach (rows[i])
		begin
			wr(rows[i].a, 32'hFFFFFFFF);
			rdChk(rows[i].a, rows[i].e);
			wr(rows[i].a, 32'h0);
		end
		// edges: ch0 rise, ch1 fall, ch2 both; timer parked at 0x1234
		wr(`MFC_ADR_CTRL_A, 32'h24);
		wr(`MFC_ADR_CTRL_B, 32'h07);
		wr(`MFC_ADR_IRQ_EN, 32'h01);
		wr(`MFC_ADR_TIMER, 32'h1234);
		pin(3'b001, 10);
		rdChk(`MFC_ADR_STATUS, 32'h01);
		rdChk(`MFC_ADR_CAP0, 32'h1234);
		chk(capIrq, 32'h1);
		pin(3'b011, 10);
		rdChk(`MFC_ADR_STATUS, 32'h01);
		pin(3'b001, 10);
		rdChk(`MFC_ADR_STATUS, 32'h03);
		pin(3'b101, 10);
		rdChk(`MFC_ADR_STATUS, 32'h07);
		wr(`MFC_ADR_STATUS, 32'h07);
		rdChk(`MFC_ADR_STATUS, 32'h00);
		chk(capIrq, 32'h0);
		// filter: a two-cycle glitch is dropped, a long pulse counts
		wr(`MFC_ADR_CTRL_B, 32'h09);
		pin(3'b000, 10);
		pin(3'b001, 1);
		pin(3'b000, 12);
		rdChk(`MFC_ADR_STATUS, 32'h00);
		pin(3'b001, 12);
		rdChk(`MFC_ADR_STATUS, 32'h01);
		wr(`MFC_ADR_STATUS, 32'h01);
		wr(`MFC_ADR_CTRL_B, 32'h00);
		// compare mode: match at 0x10 restarts from zero
		wr(`MFC_ADR_RELOAD, 32'h10);
		wr(`MFC_ADR_TIMER, 32'h0);
		wr(`MFC_ADR_IRQ_EN, 32'h02);
		wr(`MFC_ADR_TMR_CTRL, 32'h03);
		repeat (40) @(posedge clk);
		wr(`MFC_ADR_TMR_CTRL, 32'h00);
		rdChk(`MFC_ADR_STATUS, 32'h08);
		chk(tmrIrq, 32'h1);
		xfer(1'b0, `MFC_ADR_TIMER, 32'h0);
		chk(32'(rd <= 32'h10), 32'h1);
		// reload mode: reload only with reload on and clear off
		for (int m = 0; m < 3; m++)
		begin
			wr(`MFC_ADR_STATUS, 32'h08);
			wr(`MFC_ADR_RELOAD, 32'hFFF0);
			wr(`MFC_ADR_TMR_MODE, (m == 0) ? 32'h01 : (m == 1) ? 32'h09 : 32'h0);
			wr(`MFC_ADR_TIMER, 32'hFFF8);
			wr(`MFC_ADR_TMR_CTRL, 32'h02);
			repeat (12) @(posedge clk);
			wr(`MFC_ADR_TMR_CTRL, 32'h00);
			rdChk(`MFC_ADR_STATUS, 32'h08);
			xfer(1'b0, `MFC_ADR_TIMER, 32'h0);
			chk(32'(rd >= 32'hFFF0), 32'(m == 0));
		end
		wr(`MFC_ADR_TMR_MODE, 32'h0);
		wr(`MFC_ADR_STATUS, 32'h08);
		// capture clears, then reloads, the parked timer
		pin(3'b000, 10);
		wr(`MFC_ADR_CTRL_A, 32'h40);
		wr(`MFC_ADR_CTRL_B, 32'h01);
		wr(`MFC_ADR_RELOAD, 32'h0777);
		for (int m = 0; m < 2; m++)
		begin
			wr(`MFC_ADR_TMR_MODE, (m == 0) ? 32'h08 : 32'h01);
			wr(`MFC_ADR_TIMER, 32'h0500);
			pin(3'b001, 10);
			rdChk(`MFC_ADR_CAP0, 32'h0500);
			rdChk(`MFC_ADR_TIMER, (m == 0) ? 32'h0 : 32'h777);
			rdChk(`MFC_ADR_STATUS, 32'h01);
			wr(`MFC_ADR_STATUS, 32'h01);
			pin(3'b000, 10);
		end
		wr(`MFC_ADR_TMR_MODE, 32'h0);
		// encoder x4 free counting across the 16-bit boundary
		rawPins <= 3'b000;
		rawMode <= 1'b0;
		wr(`MFC_ADR_CTRL_A, 32'h00);
		wr(`MFC_ADR_CTRL_B, 32'h07);
		wr(`MFC_ADR_QEI_CTRL, 32'h01);
		wr(`MFC_ADR_CAP1, 32'hFFFE);
		steps(3, 1'b1);
		rdChk(`MFC_ADR_CAP1, 32'h0001);
		rdChk(`MFC_ADR_CAP0, 32'h0001);
		xfer(1'b0, `MFC_ADR_STATUS, 32'h0);
		chk(rd & 32'h11, 32'h11);
		wr(`MFC_ADR_STATUS, 32'h07);
		steps(2, 1'b0);
		rdChk(`MFC_ADR_CAP1, 32'hFFFF);
		rdChk(`MFC_ADR_STATUS, 32'h03);
		// x2 counts phase a edges only; count kept over mode change
		wr(`MFC_ADR_QEI_CTRL, 32'h05);
		rdChk(`MFC_ADR_CAP1, 32'hFFFF);
		steps(4, 1'b1);
		rdChk(`MFC_ADR_CAP1, 32'h0001);
		// x4 compare counting against a limit of 3
		wr(`MFC_ADR_QEI_CTRL, 32'h09);
		wr(`MFC_ADR_CAP2, 32'h0003);
		rdChk(`MFC_ADR_CAP2, 32'h0003);
		wr(`MFC_ADR_CAP1, 32'h0002);
		wr(`MFC_ADR_STATUS, 32'h07);
		steps(2, 1'b1);
		rdChk(`MFC_ADR_CAP1, 32'h0000);
		xfer(1'b0, `MFC_ADR_STATUS, 32'h0);
		chk(rd & 32'h01, 32'h01);
		wr(`MFC_ADR_STATUS, 32'h07);
		steps(1, 1'b0);
		rdChk(`MFC_ADR_CAP1, 32'h0003);
		// x2 compare: two steps give one phase a edge, wrapping 3 to 0
		wr(`MFC_ADR_QEI_CTRL, 32'h0D);
		steps(2, 1'b1);
		rdChk(`MFC_ADR_CAP1, 32'h0000);
		// disabled then re-enabled: count unchanged
		wr(`MFC_ADR_QEI_CTRL, 32'h00);
		wr(`MFC_ADR_QEI_CTRL, 32'h01);
		rdChk(`MFC_ADR_CAP1, 32'h0000);
		// index edge flags channel 2 unless index is disabled
		wr(`MFC_ADR_STATUS, 32'h07);
		pin(3'b100, 12);
		xfer(1'b0, `MFC_ADR_STATUS, 32'h0);
		chk(rd & 32'h04, 32'h04);
		wr(`MFC_ADR_STATUS, 32'h07);
		wr(`MFC_ADR_QEI_CTRL, 32'h03);
		pin(3'b000, 12);
		pin(3'b100, 12);
		xfer(1'b0, `MFC_ADR_STATUS, 32'h0);
		chk(rd & 32'h04, 32'h00);
		complete_run();
	end
endmodule : mfc_capture_qei_tb
`default_nettype wire
